// ===== verification/hdt_horizontal_tb.sv
`timescale 1ns/100ps
module hdt_horizontal_tb;
    import hdt_pkg::*;
    logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic line_start, h_blank, crt_blank, fp_blank, split_seen;
    logic [15:0] avs_address, line_len, blank_len;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [7:0] h_count;
    int fail_count = 0;
    int checked = 0;
    hdt_horizontal hdt_horizontal_inst (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .h_count,
        .line_start, .h_blank, .crt_blank, .fp_blank);
    hdt_panel_model hdt_panel_model_inst (.ref_clk, .rstn, .line_start, .h_blank, .crt_blank,
        .fp_blank, .line_len, .blank_len, .split_seen);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic t_regs;
        bus(1'b0, OFS_ACTIVE_TOTAL, 32'h0000_0000, 4'hF);
        chk("total reset", rd, RESET_ZERO);
        bus(1'b1, OFS_ACTIVE_TOTAL, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, OFS_ACTIVE_TOTAL, 32'h0000_0000, 4'hF);
        chk("total mask", rd, TOTAL_MASK);
        bus(1'b1, OFS_ACTIVE_TOTAL, 32'h0000_0000, 4'h4);
        bus(1'b0, OFS_ACTIVE_TOTAL, 32'h0000_0000, 4'hF);
        chk("lane merge", rd, 32'h0700_07FF);
        bus(1'b1, OFS_BLANK_WINDOW, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, OFS_BLANK_WINDOW, 32'h0000_0000, 4'hF);
        chk("window mask", rd, BLANK2_MASK);
        bus(1'b1, OFS_BLANK_START, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, OFS_BLANK_START, 32'h0000_0000, 4'hF);
        chk("start mask", rd, BLANK3_MASK);
        bus(1'b1, 16'h8340, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 16'h8340, 32'h0000_0000, 4'hF);
        chk("unmapped", rd, UNMAPPED_READ);
        $display("test regs done");
    endtask : t_regs
    // Line of 10 chars, blank over two chars; shift moves the window left to centre
    task automatic t_line(input logic [2:0] lo, input logic [7:0] act, input logic [7:0] shift);
        bus(1'b1, OFS_ACTIVE_TOTAL, {5'h00, 8'h09, lo, 5'h00, act, lo}, 4'hF);
        bus(1'b1, OFS_BLANK_START, {21'h00_0000, 8'h06 - shift, lo}, 4'hF);
        bus(1'b1, OFS_BLANK_WINDOW, {5'h00, 8'h08 - shift, lo, 16'h0000}, 4'hF);
        repeat (3) begin
            do @(posedge ref_clk); while (line_start !== 1'b1);
        end
        @(posedge ref_clk);
        chk("count at wrap", 32'(h_count), 32'h0000_0000);
        chk("start pulse", 32'(line_start), 32'h0000_0000);
        chk("line cycles", 32'(line_len), 32'(10 * CHAR_W));
        chk("blank cycles", 32'(blank_len), 32'(2 * CHAR_W));
        chk("outputs split", 32'(split_seen), 32'h0000_0000);
        do @(posedge ref_clk); while (h_blank !== 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, 4'hF);
        chk("status", rd, STAT_BLANK_BIT | 32'(8'h07 - shift));
        $display("test line done");
    endtask : t_line
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 16'h0000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs();
        t_line(3'h0, 8'h04, 8'h00);
        t_line(3'h7, 8'h02, 8'h01);
        conclude();
    end
endmodule : hdt_horizontal_tb

// ===== verification/hdt_panel_model.sv
`timescale 1ns/100ps
module hdt_panel_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic line_start,
    input wire logic h_blank,
    input wire logic crt_blank,
    input wire logic fp_blank,
    output logic [15:0] line_len,
    output logic [15:0] blank_len,
    output logic split_seen
);
    logic [15:0] line_cnt;
    logic [15:0] blank_cnt;
    logic blank_q;
    // Only listens; a panel never pushes back on the timing generator
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            line_cnt <= 16'h0000;
            blank_cnt <= 16'h0000;
            blank_q <= 1'b0;
            line_len <= 16'h0000;
            blank_len <= 16'h0000;
            split_seen <= 1'b0;
        end else begin
            line_cnt <= line_start ? 16'h0001 : line_cnt + 16'h0001;
            if (line_start) begin
                line_len <= line_cnt;
            end
            blank_cnt <= fp_blank ? blank_cnt + 16'h0001 : 16'h0000;
            blank_q <= fp_blank;
            if (blank_q && !fp_blank) begin
                blank_len <= blank_cnt;
            end
            if (crt_blank !== fp_blank || h_blank !== fp_blank) begin
                split_seen <= 1'b1;
            end
        end
    end
endmodule : hdt_panel_model

// ===== verilog/hdt_horizontal.sv
`timescale 1ns/100ps
module hdt_horizontal (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [hdt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] h_count,
    output logic line_start,
    output logic h_blank,
    output logic crt_blank,
    output logic fp_blank
);
    import hdt_pkg::*;

    typedef struct packed {
        logic [31:0] tot;
        logic [31:0] win;
        logic [31:0] bst;
        logic [CHAR_W-1:0] cnt;
        logic blank;
        logic lstart;
        logic ack;
        logic [31:0] rdata;
    } hdt_state_t;

    // Register select, shared by the write and the read path
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_TOTAL,
        SEL_WINDOW,
        SEL_START,
        SEL_STATUS
    } hdt_sel_t;

    hdt_state_t s_q, s_d;
    hdt_sel_t sel;
    logic char_en;

    hdt_pixdiv hdt_pixdiv_inst (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .char_en(char_en)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] msk);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r & msk;
    endfunction : merge

    // Full byte address compare; aliases would hide software address bugs
    function automatic hdt_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
        hdt_sel_t r;
        if (addr == OFS_ACTIVE_TOTAL) begin
            r = SEL_TOTAL;
        end else if (addr == OFS_BLANK_WINDOW) begin
            r = SEL_WINDOW;
        end else if (addr == OFS_BLANK_START) begin
            r = SEL_START;
        end else if (addr == OFS_STATUS) begin
            r = SEL_STATUS;
        end else begin
            r = SEL_NONE;
        end
        return r;
    endfunction : decode_sel

    logic [CHAR_W-1:0] f_total, f_active, f_bstop, f_bstart;
    logic req;
    // Low three bits of each span never reach the timing logic
    assign f_total = s_q.tot[HI_MSB:HI_LSB];
    assign f_active = s_q.tot[LO_MSB:LO_LSB];
    assign f_bstop = s_q.win[HI_MSB:HI_LSB];
    assign f_bstart = s_q.bst[LO_MSB:LO_LSB];
    assign req = (avs_read || avs_write) && !s_q.ack;
    assign sel = decode_sel(avs_address);

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.lstart = 1'b0;
        if (req && avs_write) begin
            case (sel)
                SEL_TOTAL: begin
                    s_d.tot = merge(s_q.tot, avs_writedata, avs_byteenable,
                                    TOTAL_MASK);
                end
                SEL_WINDOW: begin
                    s_d.win = merge(s_q.win, avs_writedata, avs_byteenable,
                                    BLANK2_MASK);
                end
                SEL_START: begin
                    s_d.bst = merge(s_q.bst, avs_writedata, avs_byteenable, BLANK3_MASK);
                end
                default: begin
                    // Status and unmapped writes are dropped
                end
            endcase
        end
        if (req && avs_read) begin
            case (sel)
                SEL_TOTAL: begin
                    s_d.rdata = s_q.tot;
                end
                SEL_WINDOW: begin
                    s_d.rdata = s_q.win;
                end
                SEL_START: begin
                    s_d.rdata = s_q.bst;
                end
                SEL_STATUS: begin
                    s_d.rdata = {23'h0, s_q.blank, s_q.cnt};
                end
                default: begin
                    s_d.rdata = UNMAPPED_READ;
                end
            endcase
        end
        if (char_en) begin
            if (s_q.cnt >= f_total) begin
                s_d.cnt = '0;
                s_d.lstart = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
            // Blank asserts after start field, releases at stop field plus one
            if (s_q.cnt == f_bstart) begin
                s_d.blank = 1'b1;
            end else if (s_q.cnt == f_bstop) begin
                s_d.blank = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = !s_q.ack;
    assign h_count = s_q.cnt;
    assign line_start = s_q.lstart;
    assign h_blank = s_q.blank;
    // Both outputs share one setting
    assign crt_blank = s_q.blank;
    assign fp_blank = s_q.blank;

    // Timing checks
    a_count_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
        (char_en && s_q.cnt >= f_total) |=> (h_count == 8'h00 && line_start))
        else $error("count did not wrap");
    a_count_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        (char_en && s_q.cnt < f_total) |=> (h_count == $past(h_count) + 8'h01))
        else $error("count did not step");
    a_count_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !char_en |=> $stable(h_count)) else $error("count moved off enable");
    a_start_at_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        line_start |-> h_count == 8'h00) else $error("line start off zero");
    a_pulse_short: assert property (@(posedge ref_clk) disable iff (!rstn)
        line_start |=> !line_start) else $error("line start too long");
    a_blank_end: assert property (@(posedge ref_clk) disable iff (!rstn)
        (char_en && s_q.cnt == f_bstop && s_q.cnt != f_bstart) |=> !h_blank)
        else $error("blank not released");
    a_blank_start: assert property (@(posedge ref_clk) disable iff (!rstn)
        (char_en && s_q.cnt == f_bstart) |=> h_blank) else $error("blank not set");
    a_blank_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !char_en |=> $stable(h_blank)) else $error("blank moved off enable");
    a_outputs_same: assert property (@(posedge ref_clk) disable iff (!rstn)
        crt_blank == fp_blank && h_blank == fp_blank) else $error("crt and panel differ");
    a_low_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
        (char_en && s_q.cnt < s_q.tot[HI_MSB:HI_LSB]) |=> !line_start)
        else $error("low bits affected count");

    // Register port checks
    a_rsvd_store: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req && avs_write && sel == SEL_TOTAL && avs_byteenable == 4'hF)
        |=> (s_q.tot == ($past(avs_writedata) & TOTAL_MASK) && !avs_waitrequest))
        else $error("active total not stored");
    a_bus_ack: assert property (@(posedge ref_clk) disable iff (!rstn)
        req |=> !avs_waitrequest) else $error("no bus answer");
    a_wait_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        !avs_waitrequest |=> avs_waitrequest) else $error("answer stood too long");
    a_idle_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!avs_read && !avs_write) |=> avs_waitrequest) else $error("answer without request");
    a_read_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(req && avs_read) |=> $stable(avs_readdata)) else $error("read data moved");
    a_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (req && avs_write && (sel == SEL_NONE || sel == SEL_STATUS))
        |=> ($stable(s_q.tot) && $stable(s_q.win) && $stable(s_q.bst)))
        else $error("ignored write landed");

    c_wrap: cover property (@(posedge ref_clk) disable iff (!rstn) line_start);
    c_blank_rise: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(h_blank));
    c_blank_fall: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(h_blank));
    c_write: cover property (@(posedge ref_clk) disable iff (!rstn)
        req && avs_write && sel == SEL_WINDOW);
    c_status_read: cover property (@(posedge ref_clk) disable iff (!rstn)
        req && avs_read && sel == SEL_STATUS);
endmodule : hdt_horizontal

// ===== verilog/hdt_pixdiv.sv
`timescale 1ns/100ps
module hdt_pixdiv (
    input wire logic ref_clk,
    input wire logic rstn,
    output logic char_en
);
    import hdt_pkg::*;
    typedef struct packed {
        logic [2:0] cnt;
        logic en;
    } hdt_div_t;
    hdt_div_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.cnt = s_q.cnt + 3'h1;
        s_d.en = (s_q.cnt == PIX_PER_CHAR_M1);
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign char_en = s_q.en;
    a_char_spacing: assert property (@(posedge ref_clk) disable iff (!rstn)
        char_en |=> !char_en [*7] ##1 char_en) else $error("char enable spacing");
endmodule : hdt_pixdiv

// ===== verilog/hdt_pkg.sv
package hdt_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] OFS_ACTIVE_TOTAL = 16'h8330;
    localparam logic [15:0] OFS_BLANK_WINDOW = 16'h8334;
    localparam logic [15:0] OFS_BLANK_START = 16'h8338;
    localparam logic [15:0] OFS_STATUS = 16'h833C;
    localparam int HI_MSB = 26;
    localparam int HI_LSB = 19;
    localparam int HI_RSV_LSB = 16;
    localparam int LO_MSB = 10;
    localparam int LO_LSB = 3;
    localparam int CHAR_W = 8;
    localparam logic [2:0] PIX_PER_CHAR_M1 = 3'h7;
    localparam logic [31:0] TOTAL_MASK = 32'h07FF_07FF;
    localparam logic [31:0] BLANK2_MASK = 32'h07FF_0000;
    localparam logic [31:0] BLANK3_MASK = 32'h0000_07FF;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [31:0] STAT_BLANK_BIT = 32'h0000_0100;
endpackage : hdt_pkg
